// >>> logic/fmg_guard.sv
/*
 * Flash array switching, routine download and access guard.
 * Assumes all control inputs come from logic on clk_i; the boot strap
 * is a pin and is synchronised before use.
 */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Download region in RAM is withheld
// - Routine needs 128 bytes of stack
// - Download start switches array, issued from RAM
// - Flash readable until an operation begins, except while an array switch runs
// - Flash inaccessible while program or erase runs
// - Data pointer inside flash raises an error on program, not on erase
// - Boot start reads boot array code
module fmg_guard #(
	parameter int SWITCH_CYC = fmg_pkg::SWITCH_CYC_DEF,
	parameter int DL_CYC     = fmg_pkg::DL_CYC_DEF,
	parameter int OP_CYC     = fmg_pkg::OP_CYC_DEF
) (
	input  wire logic          clk_i,
	input  wire logic          sys_rst_i,
	input  wire logic          boot_mode_i,
	input  wire logic          key_wr_i,
	input  wire logic [7:0]    key_data_i,
	input  wire logic          sel_wr_i,
	input  wire logic [7:0]    sel_data_i,
	input  wire logic          tgt_wr_i,
	input  wire logic [7:0]    tgt_data_i,
	input  wire logic          dl_start_i,
	input  wire logic          from_ram_i,
	input  wire logic          op_start_i,
	input  wire logic          op_erase_i,
	input  wire logic [23:0]   data_ptr_i,
	input  wire logic [15:0]   stack_room_i,
	input  wire logic          err_clr_i,
	input  wire logic          flash_req_i,
	input  wire logic          ram_req_i,
	input  wire logic [15:0]   ram_addr_i,
	output logic [7:0]         sel_code_o,
	output logic [7:0]         key_o,
	output logic [7:0]         tgt_o,
	output fmg_pkg::fmg_arr_t  arr_o,
	output logic               switching_o,
	output logic               dl_busy_o,
	output logic               dl_ok_o,
	output logic               dl_err_o,
	output logic               busy_o,
	output logic               ptr_err_o,
	output logic               stack_err_o,
	output logic               flash_ack_o,
	output logic               flash_deny_o,
	output logic               ram_deny_o
);
	import fmg_pkg::*;

	typedef enum logic [1:0] {
		FMG_IDLE,
		FMG_SWITCH,
		FMG_DL,
		FMG_OP
	} fmg_state_t;

	fmg_state_t  state_r;
	logic [7:0]  cnt_r;
	logic [7:0]  busy_len_r;
	logic [7:0]  sel_tgt_r;
	logic        boot_s1_r;
	logic        boot_s2_r;
	logic        init_done_r;
	logic        dl_valid_r;
	logic        dl_go;
	logic        op_req;
	logic        op_go;
	logic        ptr_in_flash;
	logic        stack_short;
	logic        sel_req;
	logic        deny;
	logic        in_region;
	logic [17:0] region_lo;
	logic [17:0] region_hi;

	// Request decode
	// A switch request wins over a download, a download over an operation
	assign dl_go = (state_r == FMG_IDLE) && init_done_r && !sel_req
		&& dl_start_i && from_ram_i
		&& (key_o == KEY_DL_UNLOCK);
	assign op_req = (state_r == FMG_IDLE) && init_done_r && op_start_i
		&& !sel_req && !dl_go;
	assign ptr_in_flash = (data_ptr_i >= FLASH_BASE)
		&& (data_ptr_i < FLASH_LIMIT);
	assign stack_short = stack_room_i < STACK_BYTES;
	assign op_go = op_req && dl_valid_r && (key_o == KEY_PROG_UNLOCK)
		&& !stack_short && (op_erase_i || !ptr_in_flash);
	assign sel_req = (state_r == FMG_IDLE) && init_done_r && sel_wr_i
		&& ((sel_data_i == SEL_BOOT_CODE) || (sel_data_i == SEL_USER_CODE))
		&& (sel_data_i != sel_code_o);
	assign deny = (state_r == FMG_SWITCH) || (state_r == FMG_OP);
	assign region_lo = 18'(tgt_o) << TGT_SHIFT;
	assign region_hi = region_lo + {2'b00, ROUTINE_BYTES};
	assign in_region = ({2'b00, ram_addr_i} >= region_lo)
		&& ({2'b00, ram_addr_i} < region_hi);

	// Boot strap synchroniser
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			boot_s1_r <= 1'b0;
			boot_s2_r <= 1'b0;
		end else begin
			boot_s1_r <= boot_mode_i;
			boot_s2_r <= boot_s1_r;
		end
	end

	// Strap capture completes on the third edge after release
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			init_done_r <= 1'b0;
			cnt_r       <= 8'h00;
		end else if (!init_done_r) begin
			cnt_r <= cnt_r + 8'h01;
			if (cnt_r == 8'h02) begin
				init_done_r <= 1'b1;
				cnt_r       <= 8'h00;
			end
		end else if (sel_req || dl_go || op_go) begin
			cnt_r <= 8'h00;
		end else if (state_r != FMG_IDLE) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	// Sequencer: switch, download and operation windows
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r <= FMG_IDLE;
		end else begin
			unique case (state_r)
				FMG_IDLE: begin
					if (!init_done_r) begin
						state_r <= FMG_IDLE;
					end else if (sel_req) begin
						state_r <= FMG_SWITCH;
					end else if (dl_go) begin
						state_r <= FMG_DL;
					end else if (op_go) begin
						state_r <= FMG_OP;
					end
				end
				FMG_SWITCH: begin
					if (cnt_r == 8'(SWITCH_CYC - 1)) begin
						state_r <= FMG_IDLE;
					end
				end
				FMG_DL: begin
					if (cnt_r == 8'(DL_CYC - 1)) begin
						state_r <= FMG_IDLE;
					end
				end
				FMG_OP: begin
					if (cnt_r == 8'(OP_CYC - 1)) begin
						state_r <= FMG_IDLE;
					end
				end
			endcase
		end
	end

	// Software-written registers and array select code
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			key_o      <= KEY_RST;
			tgt_o      <= TGT_RST;
			sel_code_o <= SEL_RST;
			sel_tgt_r  <= SEL_RST;
		end else begin
			if (key_wr_i) begin
				key_o <= key_data_i;
			end
			if (tgt_wr_i && (state_r == FMG_IDLE)) begin
				tgt_o <= tgt_data_i;
			end
			if (!init_done_r && (cnt_r == 8'h02) && boot_s2_r) begin
				sel_code_o <= SEL_BOOT_CODE;
			end else if (sel_req) begin
				sel_tgt_r <= sel_data_i;
			end else if ((state_r == FMG_SWITCH)
					&& (cnt_r == 8'(SWITCH_CYC - 1))) begin
				sel_code_o <= sel_tgt_r;
			end
		end
	end

	// Visible array: embedded storage during download
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			arr_o <= FMG_ARR_USER;
		end else if (dl_go || (state_r == FMG_DL
				&& cnt_r != 8'(DL_CYC - 1))) begin
			arr_o <= FMG_ARR_EMBED;
		end else if (state_r == FMG_SWITCH) begin
			arr_o <= FMG_ARR_USER; // Unsettled while switching
		end else if (sel_code_o == SEL_BOOT_CODE) begin
			arr_o <= FMG_ARR_BOOT;
		end else begin
			arr_o <= FMG_ARR_USER;
		end
	end

	// Status levels and sticky errors; a set beats a clear
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			switching_o <= 1'b0;
			dl_busy_o   <= 1'b0;
			busy_o      <= 1'b0;
			dl_valid_r  <= 1'b0;
			dl_ok_o     <= 1'b0;
			dl_err_o    <= 1'b0;
			ptr_err_o   <= 1'b0;
			stack_err_o <= 1'b0;
		end else begin
			switching_o <= sel_req || (state_r == FMG_SWITCH
				&& cnt_r != 8'(SWITCH_CYC - 1));
			dl_busy_o <= dl_go || (state_r == FMG_DL
				&& cnt_r != 8'(DL_CYC - 1));
			busy_o <= op_go || (state_r == FMG_OP
				&& cnt_r != 8'(OP_CYC - 1));
			if (state_r == FMG_DL && cnt_r == 8'(DL_CYC - 1)) begin
				dl_valid_r <= 1'b1;
				dl_ok_o    <= 1'b1;
			end else if (dl_go) begin
				dl_ok_o <= 1'b0;
			end
			if ((state_r == FMG_IDLE) && dl_start_i && !dl_go) begin
				dl_err_o <= 1'b1;
			end else if (err_clr_i) begin
				dl_err_o <= 1'b0;
			end
			if (op_req && !op_erase_i && ptr_in_flash) begin
				ptr_err_o <= 1'b1;
			end else if (err_clr_i) begin
				ptr_err_o <= 1'b0;
			end
			if (op_req && stack_short) begin
				stack_err_o <= 1'b1;
			end else if (err_clr_i) begin
				stack_err_o <= 1'b0;
			end
		end
	end

	// Flash and RAM access answers, one cycle after the request
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			flash_ack_o  <= 1'b0;
			flash_deny_o <= 1'b0;
			ram_deny_o   <= 1'b0;
		end else begin
			flash_ack_o  <= flash_req_i && !deny;
			flash_deny_o <= flash_req_i && deny;
			ram_deny_o   <= ram_req_i && dl_valid_r && in_region;
		end
	end

	localparam int DL_MAX = 300;

	// Length of the current operation window, read by a_busy_hold
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy_len_r <= 8'h00;
		end else if (busy_o) begin
			busy_len_r <= busy_len_r + 8'h01;
		end else begin
			busy_len_r <= 8'h00;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_dl_go;
		dl_go;
	endsequence
	sequence s_dl_done;
		$fell(dl_busy_o) && dl_ok_o;
	endsequence

	property p_dl_seq;
		s_dl_go |=> dl_busy_o && !dl_ok_o ##[1:DL_MAX] s_dl_done;
	endproperty
	a_dl_seq: assert property (p_dl_seq)
		else $error("download did not finish with ok");
	property p_op_deny;
		(state_r == FMG_OP) && flash_req_i |=> flash_deny_o && !flash_ack_o;
	endproperty
	a_op_deny: assert property (p_op_deny)
		else $error("flash served during operation");
	property p_idle_ack;
		(state_r == FMG_IDLE) && flash_req_i |=> flash_ack_o;
	endproperty
	a_idle_ack: assert property (p_idle_ack)
		else $error("flash refused outside operation");
	property p_sw_deny;
		switching_o && flash_req_i |=> flash_deny_o;
	endproperty
	a_sw_deny: assert property (p_sw_deny)
		else $error("flash served during array switch");
	property p_ptr_err;
		op_req && !op_erase_i && ptr_in_flash |=> ptr_err_o && !busy_o;
	endproperty
	a_ptr_err: assert property (p_ptr_err)
		else $error("flash data pointer not refused");
	property p_stack;
		op_req && stack_short |=> stack_err_o && !busy_o;
	endproperty
	a_stack: assert property (p_stack)
		else $error("short stack not refused");
	property p_ram_deny;
		ram_req_i && dl_valid_r && in_region |=> ram_deny_o;
	endproperty
	a_ram_deny: assert property (p_ram_deny)
		else $error("download region not withheld");
	property p_busy_hold;
		$fell(busy_o) |-> busy_len_r == 8'(OP_CYC);
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("operation ended too early");
	property p_boot_code;
		$rose(init_done_r) && boot_s2_r |=> sel_code_o == SEL_BOOT_CODE;
	endproperty
	a_boot_code: assert property (p_boot_code)
		else $error("boot start code missing");
endmodule
`default_nettype wire

// >>> logic/fmg_pkg.sv
/*
 * Shared constants for the flash array switch and access guard.
 * Assumes a single 100 MHz system clock and software-driven control ports.
 */
`default_nettype none
package fmg_pkg;
	// Key values that unlock download and programming
	localparam logic [7:0] KEY_DL_UNLOCK   = 8'hA5;
	localparam logic [7:0] KEY_PROG_UNLOCK = 8'h5A;
	localparam logic [7:0] KEY_RST         = 8'h00;
	// Array select codes
	localparam logic [7:0] SEL_BOOT_CODE   = 8'hAA;
	localparam logic [7:0] SEL_USER_CODE   = 8'h00;
	localparam logic [7:0] SEL_RST         = 8'h00;
	localparam logic [7:0] TGT_RST         = 8'h00;
	// Stack the embedded routine consumes, in bytes
	localparam logic [15:0] STACK_BYTES    = 16'h0080;
	// Download target unit: one step of the target register is 1 KiB
	localparam int TGT_SHIFT               = 10;
	localparam logic [15:0] ROUTINE_BYTES  = 16'h0400;
	// Flash window in the address map
	localparam logic [23:0] FLASH_BASE     = 24'h000000;
	localparam logic [23:0] FLASH_LIMIT    = 24'h080000;
	// Default durations in system clock cycles
	localparam int SWITCH_CYC_DEF          = 4;
	localparam int DL_CYC_DEF              = 16;
	localparam int OP_CYC_DEF              = 32;
	// Which array the flash space currently shows
	typedef enum logic [1:0] {
		FMG_ARR_USER,
		FMG_ARR_BOOT,
		FMG_ARR_EMBED
	} fmg_arr_t;
endpackage
`default_nettype wire

// >>> dv/test_fmg_guard.sv
/*
 * Self-checking bench for the flash array switch and access guard.
 * Assumes the guard alone on one 100 MHz clock, driven port by port.
 */
`timescale 1ns/10ps
`default_nettype none
module test_fmg_guard;
	import fmg_pkg::*;
	localparam int SW = 2;
	localparam int DL = 4;
	localparam int OP = 4;
	localparam int RST_LONG = 10001;
	logic             clk_i, sys_rst_i, boot_mode_i, key_wr_i, sel_wr_i;
	logic             tgt_wr_i, dl_start_i, from_ram_i, op_start_i;
	logic             op_erase_i, err_clr_i, flash_req_i, ram_req_i;
	logic [7:0]       key_data_i, sel_data_i, tgt_data_i;
	logic [23:0]      data_ptr_i;
	logic [15:0]      stack_room_i, ram_addr_i;
	logic [7:0]       sel_code_o, key_o, tgt_o;
	fmg_arr_t         arr_o;
	logic             switching_o, dl_busy_o, dl_ok_o, dl_err_o, busy_o;
	logic             ptr_err_o, stack_err_o, flash_ack_o, flash_deny_o;
	logic             ram_deny_o;
	int               fail_count, cmp_count, hi, dn, ae, tgt;
	fmg_guard #(.SWITCH_CYC(SW), .DL_CYC(DL), .OP_CYC(OP)) fmg_guard_inst (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .boot_mode_i(boot_mode_i),
		.key_wr_i(key_wr_i), .key_data_i(key_data_i), .sel_wr_i(sel_wr_i),
		.sel_data_i(sel_data_i), .tgt_wr_i(tgt_wr_i),
		.tgt_data_i(tgt_data_i), .dl_start_i(dl_start_i),
		.from_ram_i(from_ram_i), .op_start_i(op_start_i),
		.op_erase_i(op_erase_i), .data_ptr_i(data_ptr_i),
		.stack_room_i(stack_room_i), .err_clr_i(err_clr_i),
		.flash_req_i(flash_req_i), .ram_req_i(ram_req_i),
		.ram_addr_i(ram_addr_i), .sel_code_o(sel_code_o), .key_o(key_o),
		.tgt_o(tgt_o), .arr_o(arr_o), .switching_o(switching_o),
		.dl_busy_o(dl_busy_o), .dl_ok_o(dl_ok_o), .dl_err_o(dl_err_o),
		.busy_o(busy_o), .ptr_err_o(ptr_err_o), .stack_err_o(stack_err_o),
		.flash_ack_o(flash_ack_o), .flash_deny_o(flash_deny_o),
		.ram_deny_o(ram_deny_o)
	);
	// Free-running system clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Compare one value against the model
	task automatic chk(input string nm, input logic [23:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask
	// Verdict and stop
	task automatic end_sim;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// One-cycle strobe; returns on the edge that takes it
	task automatic fire(input int w);
		@(posedge clk_i);
		case (w)
			0: sel_wr_i <= 1'b1;
			1: dl_start_i <= 1'b1;
			2: op_start_i <= 1'b1;
			3: key_wr_i <= 1'b1;
			4: err_clr_i <= 1'b1;
			default: tgt_wr_i <= 1'b1;
		endcase
		@(posedge clk_i);
		{sel_wr_i, dl_start_i, op_start_i, key_wr_i} <= 4'h0;
		{err_clr_i, tgt_wr_i} <= 2'h0;
	endtask
	// Count busy cycles, denied fetches and embedded-array cycles
	task automatic meas(input int w);
		logic v;
		hi = 0;
		dn = 0;
		ae = 0;
		for (int i = 0; i < 60; i++) begin
			#1;
			v = (w == 0) ? switching_o : (w == 1) ? dl_busy_o : busy_o;
			if (flash_deny_o === 1'b1) dn++;
			if (v === 1'b1) begin
				hi++;
				if (arr_o === FMG_ARR_EMBED) ae++;
			end else if (hi > 0) begin
				repeat (2) begin
					@(posedge clk_i);
					#1;
					if (flash_deny_o === 1'b1) dn++;
				end
				return;
			end
			@(posedge clk_i);
		end
		$display("wait limit hit");
		fail_count++;
		end_sim();
	endtask
	// Key write: one-cycle key_wr_i strobe carrying the given value
	task automatic key(input logic [7:0] k);
		key_data_i <= k;
		fire(3);
	endtask
	initial begin
		{sel_wr_i, dl_start_i, op_start_i, key_wr_i, err_clr_i} = '0;
		{tgt_wr_i, from_ram_i, op_erase_i, ram_req_i} = '0;
		{key_data_i, sel_data_i, tgt_data_i} = '0;
		data_ptr_i = 24'h090000;
		stack_room_i = 16'h0080;
		ram_addr_i = 16'h0000;
		fail_count = 0;
		cmp_count = 0;
		boot_mode_i = 1'b1;
		flash_req_i = 1'b1;
		sys_rst_i = 1'b1;
		void'($urandom(58));
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		#1;
		chk("boot select", sel_code_o, SEL_BOOT_CODE);
		chk("key reset", key_o, KEY_RST);
		chk("idle fetch", flash_ack_o, 1'b1);
		$display("test reset done");
		// Switch to user array; fetches refused while switching
		sel_data_i <= SEL_USER_CODE;
		fire(0);
		meas(0);
		chk("switch len", hi, SW);
		chk("switch deny", dn, SW);
		chk("user select", sel_code_o, SEL_USER_CODE);
		sel_data_i <= 8'h55;
		fire(0);
		repeat (3) @(posedge clk_i);
		#1;
		chk("bad select", {switching_o, sel_code_o}, 9'h000);
		$display("test switch done");
		// Download refused without key, then without RAM origin
		tgt = $urandom % 60;
		tgt_data_i <= tgt[7:0];
		fire(5);
		from_ram_i <= 1'b1;
		fire(1);
		@(posedge clk_i);
		#1;
		chk("no key", dl_err_o, 1'b1);
		fire(4);
		key(KEY_DL_UNLOCK);
		from_ram_i <= 1'b0;
		fire(1);
		@(posedge clk_i);
		#1;
		chk("not ram", {dl_err_o, dl_busy_o}, 2'h2);
		fire(4);
		from_ram_i <= 1'b1;
		fire(1);
		meas(1);
		chk("dl len", hi, DL);
		chk("dl embed", ae, DL);
		chk("dl fetch", dn, 0);
		chk("dl ok", {dl_ok_o, dl_err_o, tgt_o}, {2'h2, tgt[7:0]});
		// RAM region holding the routine is withheld
		ram_req_i <= 1'b1;
		ram_addr_i <= 16'((tgt << 10) + ($urandom % 1024));
		repeat (3) @(posedge clk_i);
		#1;
		chk("ram hit", ram_deny_o, 1'b1);
		ram_addr_i <= 16'((tgt + 1) << 10);
		repeat (3) @(posedge clk_i);
		#1;
		chk("ram miss", ram_deny_o, 1'b0);
		ram_req_i <= 1'b0;
		$display("test download done");
		// Operation refusals: short stack, pointer inside flash
		key(KEY_PROG_UNLOCK);
		stack_room_i <= STACK_BYTES - 16'h0001;
		fire(2);
		@(posedge clk_i);
		#1;
		chk("stack err", {stack_err_o, busy_o}, 2'h2);
		fire(4);
		stack_room_i <= STACK_BYTES;
		data_ptr_i <= FLASH_LIMIT - 24'h000001;
		fire(2);
		@(posedge clk_i);
		#1;
		chk("ptr err", {ptr_err_o, busy_o}, 2'h2);
		fire(4);
		// Program at the flash limit, then erase; fetches refused
		for (int e = 0; e < 2; e++) begin
			op_erase_i <= e[0];
			from_ram_i <= 1'b1;
			data_ptr_i <= e ? 24'($urandom % 24'h080000) : FLASH_LIMIT;
			fire(2);
			meas(2);
			chk("op len", hi, OP);
			chk("op deny", dn, OP);
			chk("op errs", {ptr_err_o, stack_err_o}, 2'h0);
		end
		$display("test operation done");
		// Clear the key, then a long reset once the operation is over
		key(KEY_RST);
		#1;
		chk("key cleared", key_o, KEY_RST);
		sys_rst_i <= 1'b1;
		repeat (RST_LONG) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		#1;
		chk("reset state", {busy_o, dl_ok_o, tgt_o}, 10'h000);
		chk("boot again", sel_code_o, SEL_BOOT_CODE);
		chk("fetch again", flash_ack_o, 1'b1);
		$display("test reset again done");
		end_sim();
	end
endmodule
`default_nettype wire
